// ---- rtl/regmask_pkg.sv ----
`default_nettype none
package regmask_pkg;
    // register map, byte addresses on the register port
    localparam logic [7:0] CONV_MASK_ADDR   = 8'h22;
    localparam logic [7:0] LINREG_MASK_ADDR = 8'h23;
    localparam logic [7:0] MEAS_SEL_ADDR    = 8'h24;
    localparam logic [7:0] MEAS_MSB_ADDR    = 8'h25;
    localparam logic [7:0] MEAS_LSB_ADDR    = 8'h26;

    // reset values
    localparam logic [7:0] CONV_MASK_RST    = 8'hcc;
    localparam logic [7:0] LINREG_MASK_RST  = 8'hcc;
    localparam logic [7:0] MEAS_SEL_RST     = 8'h00;
    localparam logic [8:0] MEAS_RESULT_RST  = 9'h000;

    // writable bits of both mask registers, reserved bits 5 and 1 stay zero
    localparam logic [7:0] MASK_WR_BITS     = 8'hdd;

    // mask field positions, unit 0 in the low nibble and unit 1 in the high one
    localparam int PG_INVALID_POS0 = 3;
    localparam int PG_VALID_POS0   = 2;
    localparam int CURLIM_POS0     = 0;
    localparam int UNIT_STRIDE     = 4;

    // measurement select field and result layout
    localparam int MEAS_SEL_POS    = 0;
    localparam int MEAS_W          = 9;
    localparam int MEAS_LSB_MA     = 20;

    // regulator indices: 0 conv0, 1 conv1, 2 linreg0, 3 linreg1
    localparam int NUM_REG         = 4;

    typedef enum logic [1:0] {
        KIND_PG_INVALID,
        KIND_PG_VALID,
        KIND_CURLIM
    } mask_kind_t;
endpackage
`default_nettype wire

// ---- rtl/regulator_irq_mask_and_meas_select.sv ----
`default_nettype none
// Functional notes
// - conv mask bit 7 set blocks conv1 power-good-invalid interrupt; clear raises it
// - conv mask bit 6, reset 1, blocks conv1 power-good-valid interrupt when set
// - conv mask bit 4, reset 0, blocks conv1 current-limit interrupt when set
// - conv mask bit 3, reset 1, blocks conv0 power-good-invalid interrupt when set
// - conv mask bit 2, reset 1, blocks conv0 power-good-valid interrupt when set
// - conv mask bit 0, reset 0, blocks conv0 current-limit interrupt when set
// - masks gate only interrupts; raw status always follows the live condition
// - linreg mask bit 7, reset 1, blocks linreg1 power-good-invalid interrupt
// - linreg mask bit 6, reset 1, blocks linreg1 power-good-valid interrupt
// - linreg mask bit 4, reset 0, blocks linreg1 current-limit interrupt
// - linreg mask bit 3, reset 1, blocks linreg0 power-good-invalid interrupt
// - linreg mask bit 2, reset 1, blocks linreg0 power-good-valid interrupt
// - linreg mask bit 0 blocks linreg0 current-limit interrupt, raw status untouched
// - select bit 0, reset 0: 0 measures converter 0, 1 converter 1
// - every write to select register starts a measurement; only way to start one
// - 9-bit average load current over two read-only registers, 20 mA per count
module regulator_irq_mask_and_meas_select (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       reg_wr_en_in,
    input  wire logic       reg_rd_en_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic [3:0] pg_invalid_raw_in,
    input  wire logic [3:0] curlim_raw_in,
    input  wire logic [3:0] pg_flag_clear_in,
    input  wire logic [3:0] curlim_flag_clear_in,
    input  wire logic       meas_done_in,
    input  wire logic [8:0] meas_result_in,
    output logic      [3:0] pg_invalid_status_out,
    output logic      [3:0] curlim_status_out,
    output logic      [3:0] pg_flag_out,
    output logic      [3:0] curlim_flag_out,
    output logic            irq_out,
    output logic            meas_start_out,
    output logic            meas_sel_out
);

    logic [7:0] conv_mask_q;
    logic [7:0] linreg_mask_q;
    logic [7:0] meas_sel_reg_q;
    logic [8:0] meas_result_q;
    logic [3:0] pg_sync1_q;
    logic [3:0] cl_sync1_q;
    logic [3:0] pg_prev_q;
    logic [3:0] cl_prev_q;
    logic [3:0] pg_set;
    logic [3:0] cl_set;
    logic [3:0] pg_flag_d;
    logic [3:0] cl_flag_d;
    logic       wr_conv_mask;
    logic       wr_linreg_mask;
    logic       wr_meas_sel;

    // one address compare shared by the write and read decoders
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        addr_hit = (addr == target);
    endfunction

    // pick one mask bit for a regulator out of its mask register
    function automatic logic mask_bit(input logic [7:0]            conv_m,
                                      input logic [7:0]            lin_m,
                                      input int                    reg_idx,
                                      input regmask_pkg::mask_kind_t kind);
        logic [7:0] m;
        int         pos;
        m   = (reg_idx < 2) ? conv_m : lin_m;
        pos = (reg_idx % 2) * regmask_pkg::UNIT_STRIDE;
        case (kind)
            regmask_pkg::KIND_PG_INVALID: pos = pos + regmask_pkg::PG_INVALID_POS0;
            regmask_pkg::KIND_PG_VALID:   pos = pos + regmask_pkg::PG_VALID_POS0;
            regmask_pkg::KIND_CURLIM:     pos = pos + regmask_pkg::CURLIM_POS0;
            default:                      pos = pos + regmask_pkg::CURLIM_POS0;
        endcase
        mask_bit = m[pos[2:0]];
    endfunction

    assign wr_conv_mask   = reg_wr_en_in && addr_hit(reg_addr_in, regmask_pkg::CONV_MASK_ADDR);
    assign wr_linreg_mask = reg_wr_en_in && addr_hit(reg_addr_in, regmask_pkg::LINREG_MASK_ADDR);
    assign wr_meas_sel    = reg_wr_en_in && addr_hit(reg_addr_in, regmask_pkg::MEAS_SEL_ADDR);

    // mask registers; reserved positions are dropped on write so they read zero
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            conv_mask_q   <= regmask_pkg::CONV_MASK_RST;
            linreg_mask_q <= regmask_pkg::LINREG_MASK_RST;
        end else begin
            if (wr_conv_mask) begin
                conv_mask_q <= reg_wdata_in & regmask_pkg::MASK_WR_BITS;
            end
            if (wr_linreg_mask) begin
                linreg_mask_q <= reg_wdata_in & regmask_pkg::MASK_WR_BITS;
            end
        end
    end

    // measurement select; a write of any value, even the same one, fires a start
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meas_sel_reg_q <= regmask_pkg::MEAS_SEL_RST;
            meas_sel_out   <= regmask_pkg::MEAS_SEL_RST[regmask_pkg::MEAS_SEL_POS];
            meas_start_out <= 1'b0;
        end else begin
            meas_start_out <= wr_meas_sel;
            if (wr_meas_sel) begin
                meas_sel_reg_q <= reg_wdata_in;
                meas_sel_out   <= reg_wdata_in[regmask_pkg::MEAS_SEL_POS];
            end
        end
    end

    // result is held until the engine reports the next one
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meas_result_q <= regmask_pkg::MEAS_RESULT_RST;
        end else if (meas_done_in) begin
            meas_result_q <= meas_result_in;
        end
    end

    // registered read port, unmapped addresses answer zero
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_en_in) begin
            if (addr_hit(reg_addr_in, regmask_pkg::CONV_MASK_ADDR)) begin
                reg_rdata_out <= conv_mask_q;
            end else if (addr_hit(reg_addr_in, regmask_pkg::LINREG_MASK_ADDR)) begin
                reg_rdata_out <= linreg_mask_q;
            end else if (addr_hit(reg_addr_in, regmask_pkg::MEAS_SEL_ADDR)) begin
                reg_rdata_out <= meas_sel_reg_q;
            end else if (addr_hit(reg_addr_in, regmask_pkg::MEAS_MSB_ADDR)) begin
                reg_rdata_out <= {7'h00, meas_result_q[8]};
            end else if (addr_hit(reg_addr_in, regmask_pkg::MEAS_LSB_ADDR)) begin
                reg_rdata_out <= meas_result_q[7:0];
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end
    end

    // analog comparators are asynchronous, so two flops before any use;
    // the raw status taps the second stage and never sees a mask
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pg_sync1_q            <= 4'h0;
            cl_sync1_q            <= 4'h0;
            pg_invalid_status_out <= 4'h0;
            curlim_status_out     <= 4'h0;
            pg_prev_q             <= 4'h0;
            cl_prev_q             <= 4'h0;
        end else begin
            pg_sync1_q            <= pg_invalid_raw_in;
            cl_sync1_q            <= curlim_raw_in;
            pg_invalid_status_out <= pg_sync1_q;
            curlim_status_out     <= cl_sync1_q;
            pg_prev_q             <= pg_invalid_status_out;
            cl_prev_q             <= curlim_status_out;
        end
    end

    // per regulator event gating: going invalid and going valid have own masks
    for (genvar i = 0; i < regmask_pkg::NUM_REG; i++) begin : g_gate
        logic inv_evt;
        logic val_evt;
        logic cl_evt;
        assign inv_evt   = pg_invalid_status_out[i] & ~pg_prev_q[i];
        assign val_evt   = ~pg_invalid_status_out[i] & pg_prev_q[i];
        assign cl_evt    = curlim_status_out[i] & ~cl_prev_q[i];
        assign pg_set[i] = (inv_evt & ~mask_bit(conv_mask_q, linreg_mask_q, i,
                                                regmask_pkg::KIND_PG_INVALID))
                         | (val_evt & ~mask_bit(conv_mask_q, linreg_mask_q, i,
                                                regmask_pkg::KIND_PG_VALID));
        assign cl_set[i] = cl_evt & ~mask_bit(conv_mask_q, linreg_mask_q, i,
                                              regmask_pkg::KIND_CURLIM);
    end

    // set beats clear so an event in the clearing cycle is not lost
    assign pg_flag_d = pg_set | (pg_flag_out & ~pg_flag_clear_in);
    assign cl_flag_d = cl_set | (curlim_flag_out & ~curlim_flag_clear_in);

    // pending flags and the summary line, both straight from flops
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pg_flag_out     <= 4'h0;
            curlim_flag_out <= 4'h0;
            irq_out         <= 1'b0;
        end else begin
            pg_flag_out     <= pg_flag_d;
            curlim_flag_out <= cl_flag_d;
            irq_out         <= |{pg_flag_d, cl_flag_d};
        end
    end

    // helper: $past looks back two cycles only once the pipe holds real samples
    logic [1:0] warm_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            warm_q <= 2'h0;
        end else if (warm_q != 2'h3) begin
            warm_q <= warm_q + 2'h1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    conv1_inv_mask_a: assert property (
        ($rose(pg_invalid_status_out[1]) && !pg_flag_out[1])
        |=> (pg_flag_out[1] == !$past(conv_mask_q[7])))
        else $error("conv1 invalid event gating wrong");
    conv1_val_mask_a: assert property (
        ($fell(pg_invalid_status_out[1]) && !pg_flag_out[1])
        |=> (pg_flag_out[1] == !$past(conv_mask_q[6])))
        else $error("conv1 valid event gating wrong");
    conv1_curlim_mask_a: assert property (
        ($rose(curlim_status_out[1]) && !curlim_flag_out[1])
        |=> (curlim_flag_out[1] == !$past(conv_mask_q[4])))
        else $error("conv1 current limit gating wrong");
    conv0_inv_mask_a: assert property (
        ($rose(pg_invalid_status_out[0]) && !pg_flag_out[0])
        |=> (pg_flag_out[0] == !$past(conv_mask_q[3])))
        else $error("conv0 invalid event gating wrong");
    conv0_val_mask_a: assert property (
        ($fell(pg_invalid_status_out[0]) && !pg_flag_out[0])
        |=> (pg_flag_out[0] == !$past(conv_mask_q[2])))
        else $error("conv0 valid event gating wrong");
    conv0_curlim_mask_a: assert property (
        ($rose(curlim_status_out[0]) && !curlim_flag_out[0])
        |=> (curlim_flag_out[0] == !$past(conv_mask_q[0])))
        else $error("conv0 current limit gating wrong");
    raw_status_live_a: assert property (
        (warm_q == 2'h3)
        |-> (pg_invalid_status_out == $past(pg_invalid_raw_in, 2))
            && (curlim_status_out == $past(curlim_raw_in, 2)))
        else $error("raw status does not follow input");
    lin1_inv_mask_a: assert property (
        ($rose(pg_invalid_status_out[3]) && !pg_flag_out[3])
        |=> (pg_flag_out[3] == !$past(linreg_mask_q[7])))
        else $error("linreg1 invalid event gating wrong");
    lin1_val_mask_a: assert property (
        ($fell(pg_invalid_status_out[3]) && !pg_flag_out[3])
        |=> (pg_flag_out[3] == !$past(linreg_mask_q[6])))
        else $error("linreg1 valid event gating wrong");
    lin1_curlim_mask_a: assert property (
        ($rose(curlim_status_out[3]) && !curlim_flag_out[3])
        |=> (curlim_flag_out[3] == !$past(linreg_mask_q[4])))
        else $error("linreg1 current limit gating wrong");
    lin0_inv_mask_a: assert property (
        ($rose(pg_invalid_status_out[2]) && !pg_flag_out[2])
        |=> (pg_flag_out[2] == !$past(linreg_mask_q[3])))
        else $error("linreg0 invalid event gating wrong");
    lin0_val_mask_a: assert property (
        ($fell(pg_invalid_status_out[2]) && !pg_flag_out[2])
        |=> (pg_flag_out[2] == !$past(linreg_mask_q[2])))
        else $error("linreg0 valid event gating wrong");
    lin0_curlim_mask_a: assert property (
        ($rose(curlim_status_out[2]) && !curlim_flag_out[2])
        |=> (curlim_flag_out[2] == !$past(linreg_mask_q[0])))
        else $error("linreg0 current limit gating wrong");
    meas_select_a: assert property (
        wr_meas_sel |=> meas_start_out && (meas_sel_out == $past(reg_wdata_in[0])))
        else $error("measurement select not taken");
    meas_start_only_a: assert property (
        meas_start_out |-> $past(wr_meas_sel))
        else $error("measurement start without select write");
    meas_result_read_a: assert property (
        (reg_rd_en_in && addr_hit(reg_addr_in, regmask_pkg::MEAS_LSB_ADDR))
        |=> (reg_rdata_out == $past(meas_result_q[7:0])))
        else $error("result low byte read wrong");
    reserved_zero_a: assert property (
        (reg_rd_en_in && addr_hit(reg_addr_in, regmask_pkg::CONV_MASK_ADDR))
        |=> (reg_rdata_out[5] == 1'b0) && (reg_rdata_out[1] == 1'b0))
        else $error("reserved mask bit reads one");
    irq_summary_a: assert property (
        irq_out == (|{pg_flag_out, curlim_flag_out}))
        else $error("interrupt line disagrees with flags");

    // register port: stored values, reserved bits and read data that holds between reads
    conv_mask_read_a: assert property (
        (reg_rd_en_in && addr_hit(reg_addr_in, regmask_pkg::CONV_MASK_ADDR))
        |=> (reg_rdata_out == $past(conv_mask_q)))
        else $error("converter mask read wrong");
    linreg_mask_read_a: assert property (
        (reg_rd_en_in && addr_hit(reg_addr_in, regmask_pkg::LINREG_MASK_ADDR))
        |=> (reg_rdata_out == $past(linreg_mask_q)))
        else $error("linreg mask read wrong");
    lin_reserved_zero_a: assert property (
        (reg_rd_en_in && addr_hit(reg_addr_in, regmask_pkg::LINREG_MASK_ADDR))
        |=> (reg_rdata_out[5] == 1'b0) && (reg_rdata_out[1] == 1'b0))
        else $error("reserved linreg mask bit reads one");
    conv_mask_write_a: assert property (
        wr_conv_mask
        |=> (conv_mask_q == ($past(reg_wdata_in) & regmask_pkg::MASK_WR_BITS)))
        else $error("converter mask write not stored");
    linreg_mask_write_a: assert property (
        wr_linreg_mask
        |=> (linreg_mask_q == ($past(reg_wdata_in) & regmask_pkg::MASK_WR_BITS)))
        else $error("linreg mask write not stored");
    unmapped_read_a: assert property (
        (reg_rd_en_in && ((reg_addr_in < regmask_pkg::CONV_MASK_ADDR)
                          || (reg_addr_in > regmask_pkg::MEAS_LSB_ADDR)))
        |=> (reg_rdata_out == 8'h00))
        else $error("unmapped address reads nonzero");
    rdata_hold_a: assert property (
        !reg_rd_en_in |=> $stable(reg_rdata_out))
        else $error("read data changed without a read");

    // measurement path: capture, high result half, select and start pulse
    meas_result_take_a: assert property (
        meas_done_in |=> (meas_result_q == $past(meas_result_in)))
        else $error("measurement result not captured");
    meas_msb_read_a: assert property (
        (reg_rd_en_in && addr_hit(reg_addr_in, regmask_pkg::MEAS_MSB_ADDR))
        |=> (reg_rdata_out == {7'h00, $past(meas_result_q[8])}))
        else $error("result high byte read wrong");
    meas_sel_hold_a: assert property (
        !wr_meas_sel |=> $stable(meas_sel_out))
        else $error("converter select changed without a write");
    start_pulse_a: assert property (
        (meas_start_out && !wr_meas_sel) |=> !meas_start_out)
        else $error("measurement start longer than one cycle");

    // flag bookkeeping: a set is never lost, and only a clear drops a flag
    pg_set_wins_a: assert property (
        (|pg_set) |=> ((pg_flag_out & $past(pg_set)) == $past(pg_set)))
        else $error("power good event lost to a clear");
    cl_set_wins_a: assert property (
        (|cl_set) |=> ((curlim_flag_out & $past(cl_set)) == $past(cl_set)))
        else $error("current limit event lost to a clear");
    pg_flag_hold_a: assert property (
        (|(pg_flag_out & ~pg_flag_clear_in))
        |=> ((pg_flag_out & $past(pg_flag_out & ~pg_flag_clear_in))
             == $past(pg_flag_out & ~pg_flag_clear_in)))
        else $error("power good flag dropped without a clear");
    cl_flag_hold_a: assert property (
        (|(curlim_flag_out & ~curlim_flag_clear_in))
        |=> ((curlim_flag_out & $past(curlim_flag_out & ~curlim_flag_clear_in))
             == $past(curlim_flag_out & ~curlim_flag_clear_in)))
        else $error("current limit flag dropped without a clear");

endmodule
`default_nettype wire

// ---- verification/meas_engine_model.sv ----
`default_nettype none
// stand-in for the load-current measurement engine beside the block
module meas_engine_model #(
    parameter int         LAT  = 5,
    parameter logic [8:0] RES0 = 9'h1a5,
    parameter logic [8:0] RES1 = 9'h0c3
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       start_in,
    input  wire logic       sel_in,
    output var  logic       done_out,
    output var  logic [8:0] result_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int   cnt_q;
    logic sel_q;

    // a new start always restarts the count, so only the latest request answers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q      <= 0;
            sel_q      <= 1'b0;
            done_out   <= 1'b0;
            result_out <= 9'h155;
        end else begin
            done_out <= 1'b0;
            if (done_out) begin
                result_out <= ~result_out; // result inverted: no stale value lingers
            end
            if (start_in) begin
                cnt_q <= LAT;
                sel_q <= sel_in;
            end else if (cnt_q == 1) begin
                cnt_q      <= 0;
                done_out   <= 1'b1;
                result_out <= sel_q ? RES1 : RES0;
            end else if (cnt_q != 0) begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/regulator_irq_mask_and_meas_select_tb.sv ----
`default_nettype none
module regulator_irq_mask_and_meas_select_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [8:0] RES0 = 9'h1a5;
    localparam logic [8:0] RES1 = 9'h0c3;
    localparam logic [7:0] CONV_RST = regmask_pkg::CONV_MASK_RST;
    localparam logic [7:0] LIN_RST  = regmask_pkg::LINREG_MASK_RST;
    logic       clk_in = 1'b0, rst_n_in = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [3:0] pg_raw = 4'h0, cl_raw = 4'h0, pg_clr = 4'h0, cl_clr = 4'h0;
    logic [3:0] pg_st, cl_st, pg_flag, cl_flag;
    logic       irq, start, sel, done;
    logic [8:0] result;
    int         failures = 0, compares = 0, cycles = 0;

    always #50 clk_in = ~clk_in;

    regulator_irq_mask_and_meas_select uut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .pg_invalid_raw_in(pg_raw), .curlim_raw_in(cl_raw), .pg_flag_clear_in(pg_clr),
        .curlim_flag_clear_in(cl_clr), .meas_done_in(done), .meas_result_in(result),
        .pg_invalid_status_out(pg_st), .curlim_status_out(cl_st), .pg_flag_out(pg_flag),
        .curlim_flag_out(cl_flag), .irq_out(irq), .meas_start_out(start), .meas_sel_out(sel));

    meas_engine_model #(.LAT(5), .RES0(RES0), .RES1(RES1)) engine (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start), .sel_in(sel),
        .done_out(done), .result_out(result));

    task automatic finish_test();
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a hang ends in the same closing report
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            finish_test();
        end
    end

    task automatic chk(input string n, input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // strobes are one cycle wide, so each access costs two falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        wr_en = 1'b1;
        addr  = a;
        wdata = d;
        @(negedge clk_in);
        wr_en = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        @(negedge clk_in);
        rd_en = 1'b1;
        addr  = a;
        @(negedge clk_in);
        rd_en = 1'b0;
        chk(n, {1'b0, rdata}, {1'b0, e});
    endtask

    // one interrupt source: k 0 invalid edge, 1 valid edge, 2 current limit
    task automatic ev(input int u, input int k, input bit m);
        logic [7:0] ma, bm;
        logic [8:0] fe;
        ma = (u < 2) ? regmask_pkg::CONV_MASK_ADDR : regmask_pkg::LINREG_MASK_ADDR;
        bm = 8'h01 << ((u % 2) * regmask_pkg::UNIT_STRIDE + ((k == 0) ?
             regmask_pkg::PG_INVALID_POS0 : (k == 1) ? regmask_pkg::PG_VALID_POS0 :
             regmask_pkg::CURLIM_POS0));
        fe = m ? 9'h000 : 9'h001 << u;
        wr(regmask_pkg::CONV_MASK_ADDR, regmask_pkg::MASK_WR_BITS);
        wr(regmask_pkg::LINREG_MASK_ADDR, regmask_pkg::MASK_WR_BITS);
        if (k == 1) begin
            pg_raw[u] = 1'b1;
            idle(4);
        end
        if (!m) wr(ma, regmask_pkg::MASK_WR_BITS & ~bm);
        if (k == 0) pg_raw[u] = 1'b1;
        else if (k == 1) pg_raw[u] = 1'b0;
        else cl_raw[u] = 1'b1;
        idle(4);
        chk("status", (k == 2) ? cl_st[u] : pg_st[u], (k != 1));
        if (k == 0) chk("inv flag", {5'h00, pg_flag}, fe);
        else if (k == 1) chk("valid flag", {5'h00, pg_flag}, fe);
        else chk("curlim flag", {5'h00, cl_flag}, fe);
        wr(ma, regmask_pkg::MASK_WR_BITS);
        chk("irq held", irq, !m);
        pg_raw = 4'h0;
        cl_raw = 4'h0;
        idle(4);
        pg_clr = 4'hf;
        cl_clr = 4'hf;
        @(negedge clk_in);
        pg_clr = 4'h0;
        cl_clr = 4'h0;
        idle(2);
        chk("irq cleared", {irq, pg_flag, cl_flag}, 9'h000);
    endtask

    initial begin
        logic [7:0] sv;
        logic [8:0] r;
        idle(8);
        rst_n_in = 1'b1;
        idle(2);
        rd(regmask_pkg::CONV_MASK_ADDR, CONV_RST, "conv mask");
        rd(regmask_pkg::LINREG_MASK_ADDR, LIN_RST, "linreg mask");
        rd(regmask_pkg::MEAS_SEL_ADDR, 8'h00, "select");
        rd(regmask_pkg::MEAS_LSB_ADDR, 8'h00, "result lsb");
        rd(8'h30, 8'h00, "unmapped");
        wr(regmask_pkg::LINREG_MASK_ADDR, 8'hff);
        rd(regmask_pkg::LINREG_MASK_ADDR, regmask_pkg::MASK_WR_BITS, "reserved");
        wr(regmask_pkg::CONV_MASK_ADDR, 8'hff);
        rd(regmask_pkg::CONV_MASK_ADDR, regmask_pkg::MASK_WR_BITS, "conv reserved");
        for (int u = 0; u < 4; u++) begin
            for (int k = 0; k < 3; k++) begin
                ev(u, k, 1'b1);
                ev(u, k, 1'b0);
            end
        end
        // repeated identical writes must each start a fresh measurement
        for (int i = 0; i < 3; i++) begin
            sv = (i < 2) ? 8'h81 : 8'h00;
            r  = sv[0] ? RES1 : RES0;
            wr(regmask_pkg::MEAS_SEL_ADDR, sv);
            chk("start", {7'h00, start, sel}, {7'h00, 1'b1, sv[0]});
            idle(1);
            chk("start pulse", start, 1'b0);
            idle(8);
            rd(regmask_pkg::MEAS_MSB_ADDR, {7'h00, r[8]}, "result msb");
            rd(regmask_pkg::MEAS_LSB_ADDR, r[7:0], "result lsb");
            rd(regmask_pkg::MEAS_SEL_ADDR, sv, "select");
        end
        wr(regmask_pkg::MEAS_MSB_ADDR, 8'hff);
        chk("no start", start, 1'b0);
        rd(regmask_pkg::MEAS_MSB_ADDR, {7'h00, RES0[8]}, "result ro");
        finish_test();
    end
endmodule
`default_nettype wire
